//--- core/shcs_pkg.sv
package shcs_pkg;
  localparam logic [7:0] SHCS_OFF_CSR = 8'h00;
  localparam logic [7:0] SHCS_OFF_TX = 8'h04;
  localparam logic [7:0] SHCS_OFF_RX = 8'h08;
  localparam logic [7:0] SHCS_OFF_EVT = 8'h0c;
  localparam int SHCS_B_EN = 0;
  localparam int SHCS_B_I2C = 1;
  localparam int SHCS_B_WS = 2;
  localparam int SHCS_B_DEPTH = 5;
  localparam int SHCS_B_MST = 6;
  localparam int SHCS_B_RQ = 7;
  localparam int SHCS_B_IDLE = 9;
  localparam int SHCS_B_BIE = 10;
  localparam int SHCS_B_TIE = 11;
  localparam int SHCS_B_RIE = 12;
  localparam int SHCS_B_TUE = 14;
  localparam int SHCS_B_TDE = 15;
  localparam int SHCS_B_RNE = 17;
  localparam int SHCS_B_RFF = 19;
  localparam int SHCS_B_ROE = 20;
  localparam int SHCS_B_BER = 21;
  localparam int SHCS_B_BUSY = 22;
  localparam int SHCS_RX_DEEP = 10;
  localparam logic [1:0] SHCS_TR_IDLE = 2'h0;
  localparam logic [1:0] SHCS_TR_NONSEQ = 2'h2;
  localparam logic [1:0] SHCS_RIE_NE = 2'h1;
  localparam logic [1:0] SHCS_RIE_FF = 2'h3;
  localparam logic [1:0] SHCS_RQ_RX = 2'h1;
  localparam logic [1:0] SHCS_RQ_TX = 2'h2;
  localparam logic [1:0] SHCS_RQ_BOTH = 2'h3;

  typedef struct packed {
    logic [1:0] rx_irq_en;
    logic tx_irq_en;
    logic bus_error_irq_en;
    logic [1:0] request_pin_mode;
    logic master_select;
    logic rx_depth_select;
    logic [1:0] word_size_select;
    logic bus_protocol_select;
    logic iface_enable;
  } shcs_ctrl_t;

  typedef struct packed {
    logic bus_err;
    logic tx_data;
    logic tx_underrun;
    logic rx_data;
    logic rx_overrun;
  } shcs_irq_t;

  typedef struct packed {
    logic word_done;
    logic shift_empty;
    logic underrun;
    logic rx_word;
    logic start_seen;
    logic stop_seen;
    logic nack;
  } shcs_evt_t;
endpackage

//--- core/shcs_top.sv
// Behaviour
// RULE1: stop or individual reset returns status bits to reset values; control kept.
// RULE2: iface_enable bit 0 enables port; clearing it keeps control bits.
// RULE3: individual reset tristates pins, resets paths; entered one cycle after clear.
// RULE4: bus_protocol_select bit 1: 0 SPI, 1 I2C; steers pin function.
// RULE5: word_size_select bits 3-2: 8, 16, 24 bit, 11 reserved.
// RULE6: software changes word size and request mode only while not busy.
// RULE7: reserved bits 23, 18, 16, 4 read as zero.
// RULE8: rx_depth_select bit 5: one-entry or ten-entry receive fifo.
// RULE9: software resets port before changing protocol, depth or role.
// RULE10: master_select bit 6; spi master sets bus error when ss asserted.
// RULE11: i2c master generates start, clock pulses and stop.
// RULE12: request mode 00 tristates pin; master uses it as clock-suspend input.
// RULE13: slave drives request pin: rx ready, tx ready, either or both.
// RULE14: bus_idle_flag set by csr write, cleared by tx write, forced outside.
// RULE15: tx write while idle gives stop, start, then address byte.
// RULE16: idle clear sends words unchanged; no data suspends after ack.
// RULE17: receiver acks with idle value; full fifo suspends before ack.
// RULE18: idle clear means bus held; setting idle issues a stop.
// RULE19: bus-error interrupt when enable and flag both set.
// RULE20: tx interrupt on empty without underrun, underrun vector otherwise.
// RULE21: rx_irq_en 00 disables receive interrupts, others per condition.
// RULE22: clearing an interrupt enable masks pending request one cycle later.
// RULE23: hard and soft reset clear every control bit.
// RULE24: rx code 01 not-empty, 11 full, overrun vector on overrun.
// RULE25: busy between start and stop, follows ss, or spi master data held.
// RULE26: tx empty set on transfer to shift register, cleared by tx write.
// RULE27: csr writes update control bits only, except idle write-to-set.
module shcs_top
  import shcs_pkg::*;
#(
  parameter int RX_WIDTH = 24
) (
  input wire logic hclk, // core clock
  input wire logic hresetn, // async hard reset
  input wire logic soft_reset, // synchronous software reset
  input wire logic stop_state, // chip stop state
  input wire logic hsel, // ahb select
  input wire logic [7:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response
  input wire logic link_clk, // serial clock pin level
  input wire logic ss_n, // slave select pin, active low
  input wire logic flow_request_in, // request pin input level
  output logic flow_request_out, // request pin drive level
  output logic flow_request_oe, // request pin enable
  input wire shcs_evt_t dp_evt, // datapath events (core clock)
  input wire logic [RX_WIDTH-1:0] rx_word_data, // received word
  output shcs_ctrl_t ctrl, // control bits to datapath
  output logic port_active, // port out of individual reset
  output logic [23:0] tx_word, // tx holding word
  output logic tx_load, // pulse: tx word loaded into shifter
  output logic addr_phase, // pulse: emit stop, start, address byte
  output logic stop_req, // pulse: emit stop
  output logic clock_hold, // suspend serial clock
  output logic ack_level, // sda level at receive ack slot
  output logic pins_oe, // serial pins may be driven
  output shcs_irq_t irq // interrupt requests
);
  shcs_ctrl_t next_ctrl;
  logic en_d;
  logic idle;
  logic tde, tue, roe, ber, busy, shift_full, ff_full;
  logic [3:0] rx_cnt;
  logic [RX_WIDTH-1:0] rx_mem [SHCS_RX_DEEP];
  logic [3:0] rd_ptr, wr_ptr;
  logic [1:0] ss_sync, clk_sync, rq_sync;
  logic clk_prev;
  logic ss_act, rq_in;
  logic wr_pend, rd_pend;
  logic [7:0] dp_addr;
  logic [3:0] depth;
  logic status_rst, i2c_mst, spi_mst, tx_wr, csr_wr, rx_rd, csr_rd, rx_push;
  logic tx_next_go;
  logic [31:0] csr_val;
  shcs_irq_t irq_raw;
  logic [3:0] en_gate;

  // two-flop synchronisers for pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ss_sync <= 2'h3;
      clk_sync <= 2'h0;
      rq_sync <= 2'h0;
    end else begin
      ss_sync <= {ss_sync[0], ss_n};
      clk_sync <= {clk_sync[0], link_clk};
      rq_sync <= {rq_sync[0], flow_request_in};
    end
  end
  assign ss_act = !ss_sync[1];
  assign rq_in = rq_sync[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_sync[1];
    end
  end

  // ahb-lite slave: zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      wr_pend <= hsel && hready && htrans == SHCS_TR_NONSEQ && hwrite;
      rd_pend <= hsel && hready && htrans == SHCS_TR_NONSEQ && !hwrite;
      if (hsel && hready) begin
        dp_addr <= haddr;
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign csr_wr = wr_pend && dp_addr == SHCS_OFF_CSR;
  assign tx_wr = wr_pend && dp_addr == SHCS_OFF_TX;
  assign csr_rd = rd_pend && dp_addr == SHCS_OFF_CSR;
  assign rx_rd = rd_pend && dp_addr == SHCS_OFF_RX;

  assign i2c_mst = ctrl.bus_protocol_select && ctrl.master_select;
  assign spi_mst = !ctrl.bus_protocol_select && ctrl.master_select;
  assign status_rst = !en_d || stop_state || soft_reset; // [RULE1] [RULE3]
  assign port_active = en_d; // [RULE2]
  assign pins_oe = en_d; // [RULE3]

  // control bits: csr writes load them; only hard and soft reset clear them
  always_comb begin
    next_ctrl = ctrl;
    if (csr_wr) begin // [RULE27] [RULE7]
      next_ctrl = {hwdata[13:10], hwdata[8:5], hwdata[3:0]}; // [RULE4] [RULE5] [RULE8] [RULE10]
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= '0; // [RULE23]
    end else if (soft_reset) begin
      ctrl <= '0; // [RULE23]
    end else begin
      ctrl <= next_ctrl; // [RULE2]
    end
  end

  // individual reset entered one cycle after the enable clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_d <= 1'b0;
    end else begin
      en_d <= ctrl.iface_enable && !soft_reset; // [RULE3]
    end
  end

  // bus idle flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle <= 1'b1;
    end else if (status_rst || !i2c_mst) begin
      idle <= 1'b1; // [RULE14]
    end else if (csr_wr && hwdata[SHCS_B_IDLE]) begin
      idle <= 1'b1; // [RULE14] [RULE27]
    end else if (tx_wr) begin
      idle <= 1'b0; // [RULE14]
    end
  end

  // stop on idle set, address phase on first tx write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_req <= 1'b0;
      addr_phase <= 1'b0;
    end else begin
      stop_req <= i2c_mst && en_d && !idle && csr_wr && hwdata[SHCS_B_IDLE]; // [RULE18]
      addr_phase <= i2c_mst && en_d && idle && tx_wr; // [RULE15] [RULE11]
    end
  end

  // transmit holding register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_word <= 24'h000000;
    end else if (tx_wr) begin
      tx_word <= hwdata[23:0]; // [RULE16]
    end
  end

  assign tx_next_go = en_d && !tde && dp_evt.shift_empty && !shift_full;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_load <= 1'b0;
    end else begin
      tx_load <= tx_next_go && !tx_wr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tde <= 1'b1;
      shift_full <= 1'b0;
    end else if (status_rst) begin
      tde <= 1'b1; // [RULE1]
      shift_full <= 1'b0;
    end else begin
      if (tx_wr) begin
        tde <= 1'b0; // [RULE26]
      end else if (tx_next_go) begin
        tde <= 1'b1; // [RULE26]
      end
      if (tx_next_go && !tx_wr) begin
        shift_full <= 1'b1;
      end else if (dp_evt.word_done) begin
        shift_full <= 1'b0;
      end
    end
  end

  // underrun: set wins over tx write clear; bus error: cleared only by status reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tue <= 1'b0;
      ber <= 1'b0;
    end else if (status_rst) begin
      tue <= 1'b0;
      ber <= 1'b0;
    end else begin
      if (dp_evt.underrun && !ctrl.master_select) begin
        tue <= 1'b1;
      end else if (tx_wr) begin
        tue <= 1'b0;
      end
      if ((spi_mst && ss_act) || (i2c_mst && dp_evt.nack)) begin
        ber <= 1'b1; // [RULE10]
      end
    end
  end

  // receive fifo
  assign depth = ctrl.rx_depth_select ? 4'(SHCS_RX_DEEP) : 4'h1; // [RULE8]
  assign ff_full = rx_cnt >= depth;
  assign rx_push = en_d && dp_evt.rx_word && !ff_full;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_cnt <= 4'h0;
      rd_ptr <= 4'h0;
      wr_ptr <= 4'h0;
      roe <= 1'b0;
    end else if (status_rst) begin
      rx_cnt <= 4'h0;
      rd_ptr <= 4'h0;
      wr_ptr <= 4'h0;
      roe <= 1'b0;
    end else begin
      if (rx_push) begin
        wr_ptr <= (wr_ptr == 4'(SHCS_RX_DEEP - 1)) ? 4'h0 : wr_ptr + 4'h1;
      end
      if (rx_rd && rx_cnt != 4'h0) begin
        rd_ptr <= (rd_ptr == 4'(SHCS_RX_DEEP - 1)) ? 4'h0 : rd_ptr + 4'h1;
      end
      rx_cnt <= rx_cnt + 4'(rx_push) - 4'(rx_rd && rx_cnt != 4'h0);
      if (dp_evt.rx_word && ff_full && !i2c_mst) begin
        roe <= 1'b1;
      end else if (rx_rd) begin
        roe <= 1'b0;
      end
    end
  end
  always_ff @(posedge hclk) begin
    if (rx_push) begin
      rx_mem[wr_ptr] <= rx_word_data;
    end
  end

  // busy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
    end else if (status_rst) begin
      busy <= 1'b0;
    end else if (ctrl.bus_protocol_select) begin
      if (dp_evt.start_seen) begin
        busy <= 1'b1; // [RULE25]
      end else if (dp_evt.stop_seen) begin
        busy <= 1'b0;
      end
    end else if (ctrl.master_select) begin
      busy <= !tde || shift_full; // [RULE25]
    end else begin
      busy <= ss_act; // [RULE25]
    end
  end

  // clock suspension and ack level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_hold <= 1'b0;
      ack_level <= 1'b1;
    end else begin
      clock_hold <= ctrl.master_select && ((ctrl.request_pin_mode != 2'h0 && !rq_in) // [RULE12]
        || (i2c_mst && ((tde && !shift_full) || ff_full))); // [RULE16] [RULE17]
      ack_level <= idle; // [RULE17]
    end
  end

  // request pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flow_request_out <= 1'b0;
      flow_request_oe <= 1'b0;
    end else begin
      flow_request_oe <= en_d && !ctrl.master_select && ctrl.request_pin_mode != 2'h0; // [RULE12]
      unique case (ctrl.request_pin_mode)
        SHCS_RQ_RX: flow_request_out <= !ff_full; // [RULE13]
        SHCS_RQ_TX: flow_request_out <= !tde || shift_full;
        SHCS_RQ_BOTH: flow_request_out <= ctrl.bus_protocol_select ?
          (!ff_full || !tde) : (!ff_full && !tde); // [RULE13]
        default: flow_request_out <= 1'b0;
      endcase
    end
  end

  // interrupts with enable masking delayed one cycle
  always_comb begin
    irq_raw = '0;
    irq_raw.bus_err = ber; // [RULE19]
    irq_raw.tx_data = tde && !tue; // [RULE20]
    irq_raw.tx_underrun = tue; // [RULE20]
    irq_raw.rx_data = (ctrl.rx_irq_en == SHCS_RIE_NE && rx_cnt != 4'h0 && !roe)
      || (ctrl.rx_irq_en == SHCS_RIE_FF && ff_full && !roe); // [RULE24] [RULE21]
    irq_raw.rx_overrun = roe && (ctrl.rx_irq_en == SHCS_RIE_NE
      || ctrl.rx_irq_en == SHCS_RIE_FF); // [RULE24]
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_gate <= 4'h0;
    end else begin
      en_gate <= {ctrl.bus_error_irq_en, ctrl.tx_irq_en, ctrl.rx_irq_en}; // [RULE22]
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= '0;
    end else begin
      irq.bus_err <= irq_raw.bus_err && en_gate[3] && en_d; // [RULE19] [RULE22]
      irq.tx_data <= irq_raw.tx_data && en_gate[2] && en_d; // [RULE20]
      irq.tx_underrun <= irq_raw.tx_underrun && en_gate[2] && en_d;
      irq.rx_data <= irq_raw.rx_data && en_gate[1:0] != 2'h0 && en_d; // [RULE21]
      irq.rx_overrun <= irq_raw.rx_overrun && en_gate[1:0] != 2'h0 && en_d;
    end
  end

  // register read view
  always_comb begin
    csr_val = 32'h00000000; // [RULE7]
    csr_val[13:10] = ctrl[11:8];
    csr_val[SHCS_B_IDLE] = idle;
    csr_val[8:5] = ctrl[7:4];
    csr_val[3:0] = ctrl[3:0];
    csr_val[SHCS_B_TUE] = tue;
    csr_val[SHCS_B_TDE] = tde;
    csr_val[SHCS_B_RNE] = rx_cnt != 4'h0;
    csr_val[SHCS_B_RFF] = ff_full;
    csr_val[SHCS_B_ROE] = roe;
    csr_val[SHCS_B_BER] = ber;
    csr_val[SHCS_B_BUSY] = busy;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hsel && hready && htrans == SHCS_TR_NONSEQ && !hwrite) begin
      unique case (haddr)
        SHCS_OFF_CSR: hrdata <= csr_val;
        SHCS_OFF_TX: hrdata <= {8'h00, tx_word};
        SHCS_OFF_RX: hrdata <= 32'(rx_mem[rd_ptr]);
        SHCS_OFF_EVT: hrdata <= {31'h00000000, clk_sync[1] != clk_prev};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end
endmodule

//--- tb/shcs_chk.sv
module shcs_chk
  import shcs_pkg::*;
(
  input wire logic hclk, // core clock
  input wire logic hresetn, // async reset
  input wire logic hsel, // ahb select
  input wire logic [7:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb ready
  input wire logic [31:0] hrdata, // ahb read data
  input wire logic flow_request_oe, // request pin enable
  input wire shcs_ctrl_t ctrl, // control bits
  input wire logic port_active, // port out of reset
  input wire logic [23:0] tx_word, // tx holding word
  input wire logic pins_oe, // serial pins enable
  input wire shcs_irq_t irq // interrupt requests
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_take;
    hsel && hready && htrans == SHCS_TR_NONSEQ;
  endsequence
  sequence s_tx_wr;
    s_take ##0 hwrite && haddr == SHCS_OFF_TX;
  endsequence
  sequence s_csr_rd;
    s_take ##0 !hwrite && haddr == SHCS_OFF_CSR;
  endsequence

  a_en_rise: assert property ($rose(ctrl.iface_enable) |-> !port_active ##1 port_active)
    else $error("port not active one cycle after enable");
  a_dis_float: assert property ($fell(ctrl.iface_enable) |=> !port_active && !pins_oe)
    else $error("pins still driven after disable");
  a_req_hiz: assert property ((ctrl.request_pin_mode == 2'h0) [*2] |-> !flow_request_oe)
    else $error("request pin driven in mode 00");
  a_req_master: assert property ((ctrl.master_select) [*2] |-> !flow_request_oe)
    else $error("request pin driven as master");
  a_berr_mask: assert property ($fell(ctrl.bus_error_irq_en) |-> ##2 !irq.bus_err)
    else $error("bus error request not masked");
  a_tx_mask: assert property ($fell(ctrl.tx_irq_en) |-> ##2 !irq.tx_data && !irq.tx_underrun)
    else $error("tx request not masked");
  a_berr_gate: assert property ((!ctrl.bus_error_irq_en) [*3] |-> !irq.bus_err)
    else $error("bus error request while disabled");
  a_rx_gate: assert property ((ctrl.rx_irq_en == 2'h0) [*3] |-> !irq.rx_data && !irq.rx_overrun)
    else $error("rx request while disabled");
  a_tx_excl: assert property (!(irq.tx_data && irq.tx_underrun))
    else $error("tx data and underrun requests together");
  a_tx_word: assert property (s_tx_wr |=> ##1 tx_word == $past(hwdata[23:0]))
    else $error("tx word differs from written data");
  a_csr_rsvd: assert property (s_csr_rd |=> hrdata[31:23] == 9'h0 && hrdata[18] == 1'b0
    && hrdata[16] == 1'b0 && hrdata[4] == 1'b0)
    else $error("reserved bits read nonzero");
endmodule

bind shcs_top shcs_chk u_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .flow_request_oe, .ctrl, .port_active, .tx_word, .pins_oe, .irq
);

//--- tb/shcs_far.sv
module shcs_far (
  output logic link_clk, // serial clock, still outside frames
  output logic ss_n, // slave select, active low
  output logic flow_request_in // request pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_clk = 1'b0;
    ss_n = 1'b1;
    flow_request_in = 1'b1;
  end
  task automatic frame(input int nbits);
    ss_n = 1'b0;
    #80;
    repeat (nbits) begin
      link_clk = 1'b1;
      #80;
      link_clk = 1'b0;
      #80;
    end
    ss_n = 1'b1;
  endtask
  task automatic hold_req(input logic lvl);
    flow_request_in <= lvl;
  endtask
endmodule

//--- tb/tb_top.sv
module tb_top
  import shcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0, hresetn = 1'b0, soft_reset = 1'b0, stop_state = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, flow_request_out, flow_request_oe;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = SHCS_TR_IDLE;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, r;
  logic [23:0] rx_word_data = 24'h0, tx_word;
  logic port_active, tx_load, addr_phase, stop_req, clock_hold, ack_level, pins_oe;
  wire hready;
  wire link_clk, ss_n, flow_request_in;
  shcs_evt_t dp_evt = '0;
  shcs_ctrl_t ctrl;
  shcs_irq_t irq;
  int errors = 0, tests_run = 0, n_addr = 0, n_stop = 0, n_load = 0;

  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  always @(posedge hclk) begin
    if (addr_phase === 1'b1) n_addr++;
    if (stop_req === 1'b1) n_stop++;
    if (tx_load === 1'b1) n_load++;
  end

  shcs_top #(.RX_WIDTH(24)) u_dut (.hclk, .hresetn, .soft_reset, .stop_state, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .link_clk, .ss_n,
    .flow_request_in, .flow_request_out, .flow_request_oe, .dp_evt, .rx_word_data, .ctrl,
    .port_active, .tx_word, .tx_load, .addr_phase, .stop_req, .clock_hold, .ack_level,
    .pins_oe, .irq);
  shcs_far u_far (.link_clk, .ss_n, .flow_request_in);

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("BAD %0t bus hang", $time);
      final_report();
    end
  endtask
  // one single transfer, entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= SHCS_TR_NONSEQ;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= SHCS_TR_IDLE;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk_w(r, exp);
  endtask
  task automatic evt(input shcs_evt_t e);
    dp_evt <= e;
    @(posedge hclk);
    dp_evt <= '0;
    @(posedge hclk);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk(8'h00, 32'h00008200);
    chk_b(pins_oe, 1'b0);
    rd_chk(8'h10, 32'h0);
    done("reset");
    wr(8'h00, 32'hfffffffa);
    wr(8'h00, 32'hfffffffb);
    rd_chk(8'h00, 32'h0000bfeb);
    @(posedge hclk);
    chk_b(irq.tx_data, 1'b1);
    chk_b(flow_request_oe, 1'b0);
    chk_b(pins_oe, 1'b1);
    wr(8'h00, 32'h000037eb);
    @(negedge hclk);
    chk_b(irq.tx_data, 1'b1);
    repeat (3) @(posedge hclk);
    chk_b(irq.tx_data, 1'b0);
    chk_b(ack_level, 1'b1);
    chk_b(clock_hold, 1'b1);
    wr(8'h04, 32'h00a5c3e1);
    rd_chk(8'h10, 32'h0);
    chk_b(n_addr == 1, 1'b1);
    chk_b(ack_level, 1'b0);
    ahb(1'b0, 8'h00, 32'h0);
    chk_b(r[9], 1'b0);
    evt(7'h20);
    ahb(1'b0, 8'h00, 32'h0);
    chk_b(r[15], 1'b1);
    chk_b(n_load > 0, 1'b1);
    chk_b(clock_hold, 1'b0);
    u_far.hold_req(1'b0);
    repeat (4) @(posedge hclk);
    chk_b(clock_hold, 1'b1);
    u_far.hold_req(1'b1);
    wr(8'h00, 32'h000037eb);
    ahb(1'b0, 8'h00, 32'h0);
    chk_b(r[9], 1'b1);
    chk_b(n_stop == 1, 1'b1);
    done("i2c master");
    wr(8'h00, 32'h000035ea);
    repeat (2) @(posedge hclk);
    chk_b(pins_oe, 1'b0);
    rd_chk(8'h00, 32'h0000b7ea);
    soft_reset <= 1'b1;
    @(posedge hclk);
    soft_reset <= 1'b0;
    @(posedge hclk);
    rd_chk(8'h00, 32'h00008200);
    done("resets");
    wr(8'h00, 32'h00001001);
    @(posedge hclk);
    rx_word_data <= 24'habcdef;
    evt(7'h08);
    rd_chk(8'h00, 32'h000a9201);
    chk_b(irq.rx_data, 1'b1);
    evt(7'h08);
    rd_chk(8'h00, 32'h001a9201);
    chk_b(irq.rx_overrun, 1'b1);
    rd_chk(8'h08, 32'h00abcdef);
    evt(7'h08);
    stop_state <= 1'b1;
    repeat (2) @(posedge hclk);
    rd_chk(8'h00, 32'h00009201);
    stop_state <= 1'b0;
    done("receive");
    for (logic [2:0] m = 3'h1; m < 3'h4; m++) begin
      wr(8'h00, {23'h0, m[1:0], 7'h01});
      repeat (3) @(posedge hclk);
      chk_b(flow_request_oe, 1'b1);
      chk_b(flow_request_out, m == 3'h1);
    end
    fork
      u_far.frame(8);
      begin
        repeat (40) @(posedge hclk);
        ahb(1'b0, 8'h00, 32'h0);
        chk_b(r[22], 1'b1);
      end
    join
    @(posedge hclk);
    repeat (4) @(posedge hclk);
    ahb(1'b0, 8'h00, 32'h0);
    chk_b(r[22], 1'b0);
    done("spi slave");
    wr(8'h00, 32'h00000440);
    wr(8'h00, 32'h00000441);
    u_far.frame(1);
    @(posedge hclk);
    ahb(1'b0, 8'h00, 32'h0);
    chk_b(r[21], 1'b1);
    chk_b(irq.bus_err, 1'b1);
    wr(8'h00, 32'h00000041);
    repeat (3) @(posedge hclk);
    chk_b(irq.bus_err, 1'b0);
    done("spi master");
    final_report();
  end
endmodule
